// ### design/asr_pkg.sv
// constants and types shared by the converter serial port files
package asr_pkg;
	// word sizes
	localparam int RES_W      = 16;   // result frame width in bits
	localparam int CODE_W     = 12;   // conversion code width
	localparam int CH_W       = 3;    // channel address width
	localparam int CTRL_W     = 5;    // control word width
	localparam int CNT_W      = 5;    // edge counter width
	localparam int FIFO_DEPTH = 2;    // result buffer entries
	// frame positions, counted in serial clock edges
	localparam logic [CNT_W-1:0] FRAME_BITS      = 5'h10; // sixteen edges
	localparam logic [CNT_W-1:0] CTRL_APPLY_EDGE = 5'h06; // control lands
	// control word fields
	localparam int CTRL_CH_HI     = 4;
	localparam int CTRL_CH_LO     = 2;
	localparam int CTRL_SWSTART   = 0;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
	// result word: top bit zero, then channel, then code
	localparam int RES_CH_LO = CODE_W;
	// self clocking serial clock timing
	localparam int CLK_PERIOD_NS     = 25;
	localparam int SELF_SCLK_HALF_NS = 100;
	localparam int SELF_HALF_CYC     = SELF_SCLK_HALF_NS / CLK_PERIOD_NS;
	localparam logic [2:0] SELF_HALF_LAST = 3'(SELF_HALF_CYC - 1);
	// core frame states
	typedef enum logic [1:0] {
		CORE_IDLE  = 2'b01,
		CORE_FRAME = 2'b10
	} asr_core_st_t;
endpackage

// ### design/asr_sar.sv
// successive approximation sequencer, bit trials on the falling clock edge
`timescale 1ns/1ps
module asr_sar
	import asr_pkg::*;
(
	// clock and reset
	input  wire logic              clk_in,
	input  wire logic              rst_n_in,
	// control
	input  wire logic              start_in,
	input  wire logic              comp_in,
	// results
	output logic                   busy_out,
	output logic                   done_out,
	output logic [CODE_W-1:0]      dac_code_out
);
	typedef struct packed {
		logic              busy;  // trials under way
		logic              done;  // one cycle at the end
		logic [3:0]        idx;   // bit under trial
		logic [CODE_W-1:0] code;  // trial and final code
	} asr_sar_t;

	asr_sar_t s_q;
	asr_sar_t s_d;

	// trial sequencing: keep the bit when the comparator says input >= dac
	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		if (s_q.busy) begin
			s_d.code[s_q.idx] = comp_in; // decide this bit
			if (s_q.idx == 4'h0) begin
				s_d.busy = 1'b0;
				s_d.done = 1'b1;
			end else begin
				s_d.idx = s_q.idx - 4'h1;
				s_d.code[s_q.idx - 4'h1] = 1'b1; // next trial bit
			end
		end else if (start_in) begin
			// start pulse lasts a full cycle so this edge sees it once
			s_d.busy = 1'b1;
			s_d.idx = 4'(CODE_W - 1);
			s_d.code = '0;
			s_d.code[CODE_W-1] = 1'b1;
		end
	end

	// falling edge keeps decisions away from rising edge digital noise
	always_ff @(negedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign busy_out     = s_q.busy;
	assign done_out     = s_q.done;
	assign dac_code_out = s_q.code;
endmodule

// ### design/asr_port.sv
// serial result and control port of the eight channel sampling converter
//
// Summary of operation
// - self clocking: device drives clock and frame sync
// - serial clock is master clock divided by eight
// - finished conversion is sent without any request
// - every frame carries sixteen serial bits
// - write sync with frame shifts in control bits
// - external clocking: access allowed during conversion
// - bit decisions on master clock falling edge
// - data output driver off during write-only frames
// - software start lands on sixth clock edge
// - read continues ten edges after that
// - result shifted out most significant bit first
`timescale 1ns/1ps
module asr_port
	import asr_pkg::*;
(
	// master clock and reset
	input  wire logic            clk_in,
	input  wire logic            rst_n_in,
	// mode strap: high selects self clocking
	input  wire logic            self_clock_mode_in,
	// conversion start and analog side
	input  wire logic            conversion_trigger_n_in,
	input  wire logic            comp_in,
	output logic [CODE_W-1:0]    dac_code_out,
	output logic [CH_W-1:0]      channel_select_out,
	output logic                 conversion_busy_out,
	// serial clock pin, link clock port in external mode
	input  wire logic            sclk_in,
	output logic                 sclk_out,
	output logic                 sclk_oe_out,
	// result frame sync pin, active low
	input  wire logic            result_frame_sync_n_in,
	output logic                 result_frame_sync_n_out,
	output logic                 result_frame_sync_oe_out,
	// write frame sync, active low, always an input
	input  wire logic            write_frame_sync_n_in,
	// serial data
	input  wire logic            data_in,
	output logic                 data_out,
	output logic                 data_oe_out
);
	// core state on the master clock
	typedef struct packed {
		asr_core_st_t                st;       // frame sequencer
		logic [1:0]                  mode_s;   // strap synchroniser
		logic [2:0]                  trig_s;   // trigger sync plus prev
		logic [1:0]                  tfs_s;    // write sync synchroniser
		logic [1:0]                  din_s;    // data synchroniser
		logic [2:0]                  ctg_s;    // link control toggle
		logic [2:0]                  ack_s;    // link ack toggle
		logic [1:0]                  bsy_s;    // link frame active
		logic [CTRL_W-1:0]           ctrl;     // control register
		logic [CH_W-1:0]             conv_ch;  // channel being converted
		logic                        start;    // start pulse to sequencer
		logic [FIFO_DEPTH-1:0][RES_W-1:0] fifo; // result buffer
		logic                        wp;       // write index
		logic                        rp;       // read index
		logic [1:0]                  cnt;      // entries held
		logic [RES_W-1:0]            ext_word; // word offered to link
		logic                        ext_full; // link has not taken it
		logic [RES_W-1:0]            sh;       // outgoing shift
		logic [CTRL_W-1:0]           wr;       // incoming control bits
		logic                        wr_en;    // write sync seen
		logic [CNT_W-1:0]            edge_n;   // falling edges so far
		logic                        ph;       // 1 = clock high half
		logic [2:0]                  hc;       // half period counter
		logic                        sclk;     // serial clock out
		logic                        rfs_n;    // frame sync out
		logic                        dout;     // data out
		logic                        doe;      // data driver enable
	} asr_core_t;

	// link state on the host serial clock
	typedef struct packed {
		logic [1:0]        mode_s; // strap seen on this clock
		logic              act;    // frame under way
		logic              rd;     // frame reads a result
		logic [CNT_W-1:0]  edge_n; // edges since frame sync
		logic [RES_W-1:0]  sh;     // outgoing shift
		logic [CTRL_W-1:0] wr;     // incoming control bits
		logic              wr_en;  // write sync seen at start
		logic [CTRL_W-1:0] ctrl;   // word handed to the core
		logic              ctg;    // toggles per control word
		logic              ack;    // toggles per result taken
		logic              dout;   // data out
		logic              doe;    // data driver enable
	} asr_link_t;

	asr_core_t c_q;
	asr_core_t c_d;
	asr_link_t l_q;
	asr_link_t l_d;

	logic              sar_busy;  // sequencer running
	logic              sar_done;  // sequencer finished
	logic [CODE_W-1:0] sar_code;  // sequencer code

	// sequencer trials on the falling master clock edge
	asr_sar u_sar (
		.clk_in       (clk_in),
		.rst_n_in     (rst_n_in),
		.start_in     (c_q.start),
		.comp_in      (comp_in),
		.busy_out     (sar_busy),
		.done_out     (sar_done),
		.dac_code_out (sar_code)
	);

	// core next state: strap, starts, buffer and self clocked frames
	always_comb begin
		logic self_m;     // self clocking mode
		logic push;       // new result into buffer
		logic pop;        // buffer head taken
		logic sw_start;   // software start request
		logic [CTRL_W-1:0] new_ctrl; // control word to apply
		logic new_ctrl_v; // a control word arrived
		self_m     = 1'b0;
		push       = 1'b0;
		pop        = 1'b0;
		sw_start   = 1'b0;
		new_ctrl   = CTRL_RESET;
		new_ctrl_v = 1'b0;
		c_d = c_q;
		// two stage synchronisers; only the second stage and the prev bits are read
		c_d.mode_s = {c_q.mode_s[0], self_clock_mode_in};
		c_d.trig_s = {c_q.trig_s[1:0], conversion_trigger_n_in};
		c_d.tfs_s  = {c_q.tfs_s[0], write_frame_sync_n_in};
		c_d.din_s  = {c_q.din_s[0], data_in};
		c_d.ctg_s  = {c_q.ctg_s[1:0], l_q.ctg};
		c_d.ack_s  = {c_q.ack_s[1:0], l_q.ack};
		c_d.bsy_s  = {c_q.bsy_s[0], l_q.act};
		self_m = c_q.mode_s[1];
		c_d.start = 1'b0;

		// control word from the link; word is stable once toggle moves
		if (c_q.ctg_s[2] != c_q.ctg_s[1]) begin
			new_ctrl   = l_q.ctrl;
			new_ctrl_v = 1'b1;
		end

		// self clocked frame sequencer
		case (c_q.st)
			CORE_IDLE: begin
				c_d.sclk  = 1'b0;
				c_d.rfs_n = 1'b1;
				c_d.doe   = 1'b0;
				// result waiting: send it unasked
				if (self_m && c_q.cnt != 2'h0) begin
					pop       = 1'b1;
					c_d.st    = CORE_FRAME;
					c_d.rfs_n = 1'b0;
					c_d.sh    = c_q.fifo[c_q.rp];
					c_d.dout  = c_q.fifo[c_q.rp][RES_W-1];
					c_d.doe   = 1'b1;
					c_d.sclk  = 1'b1;
					c_d.ph    = 1'b1;
					c_d.hc    = 3'h0;
					c_d.edge_n = '0;
					// tied syncs: host word goes in with the result
					c_d.wr_en = !c_q.tfs_s[1];
				end
			end
			CORE_FRAME: begin
				// tied syncs reach the synchroniser only after the frame
				// opens, so keep looking for them up to the first fall
				if (c_q.edge_n == '0 && !c_q.tfs_s[1])
					c_d.wr_en = 1'b1;
				c_d.hc = c_q.hc + 3'h1;
				if (c_q.hc == SELF_HALF_LAST) begin
					c_d.hc = 3'h0;
					if (c_q.ph) begin
						// falling edge: count it and sample data
						c_d.ph   = 1'b0;
						c_d.sclk = 1'b0;
						c_d.edge_n = c_q.edge_n + 5'h01;
						if (c_q.wr_en && c_q.edge_n < CTRL_APPLY_EDGE - 5'h01)
							c_d.wr = {c_q.wr[CTRL_W-2:0], c_q.din_s[1]};
						if (c_q.wr_en && c_d.edge_n == CTRL_APPLY_EDGE) begin
							new_ctrl   = c_q.wr;
							new_ctrl_v = 1'b1;
						end
					end else if (c_q.edge_n == FRAME_BITS) begin
						// sixteen bits done, ten past the sixth
						c_d.st    = CORE_IDLE;
						c_d.rfs_n = 1'b1;
						c_d.doe   = 1'b0;
						c_d.wr_en = 1'b0;
					end else begin
						// rising edge: next bit, msb first
						c_d.ph   = 1'b1;
						c_d.sclk = 1'b1;
						c_d.sh   = {c_q.sh[RES_W-2:0], 1'b0};
						c_d.dout = c_q.sh[RES_W-2];
					end
				end
			end
			default: begin
				c_d.st = CORE_IDLE;
			end
		endcase

		// apply a control word from either domain
		if (new_ctrl_v) begin
			c_d.ctrl = new_ctrl;
			sw_start = new_ctrl[CTRL_SWSTART];
		end

		// external mode: offer buffer head when link is idle
		if (c_q.ack_s[2] != c_q.ack_s[1])
			c_d.ext_full = 1'b0;
		if (!self_m && !c_q.ext_full && !c_q.bsy_s[1] && c_q.cnt != 2'h0
			&& c_q.ack_s[2] == c_q.ack_s[1]) begin
			pop          = 1'b1;
			c_d.ext_word = c_q.fifo[c_q.rp];
			c_d.ext_full = 1'b1;
		end

		// start on trigger rising edge or software start; a full buffer
		// refuses the start, tested on the count from before any push that cycle
		if ((c_q.trig_s[1] && !c_q.trig_s[2]) || sw_start) begin
			if (!sar_busy && !c_q.start && c_q.cnt != 2'(FIFO_DEPTH)) begin
				c_d.start   = 1'b1;
				c_d.conv_ch = c_d.ctrl[CTRL_CH_HI:CTRL_CH_LO];
			end
		end

		// buffer bookkeeping
		push = sar_done;
		if (push) begin
			c_d.fifo[c_q.wp] = {1'b0, c_q.conv_ch, sar_code};
			c_d.wp = !c_q.wp;
		end
		if (pop)
			c_d.rp = !c_q.rp;
		c_d.cnt = c_q.cnt + {1'b0, push} - {1'b0, pop};
	end

	// core registers
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			c_q       <= '0;
			c_q.st    <= CORE_IDLE;
			c_q.ctrl  <= CTRL_RESET;
			c_q.rfs_n <= 1'b1;
			c_q.trig_s <= 3'h7;
			c_q.tfs_s <= 2'h3;
		end else begin
			c_q <= c_d;
		end
	end

	// link next state: host clocked reads and writes, even mid conversion
	always_comb begin
		l_d = l_q;
		l_d.mode_s = {l_q.mode_s[0], self_clock_mode_in};
		if (l_q.mode_s[1]) begin
			l_d.act = 1'b0;
			l_d.doe = 1'b0;
		end else if (!l_q.act) begin
			if (!result_frame_sync_n_in || !write_frame_sync_n_in) begin
				// frame begins on this edge, count it as edge one
				l_d.act    = 1'b1;
				l_d.edge_n = 5'h01;
				l_d.rd     = !result_frame_sync_n_in;
				l_d.wr_en  = !write_frame_sync_n_in;
				l_d.sh     = c_q.ext_word;
				l_d.dout   = c_q.ext_word[RES_W-1];
				l_d.doe    = !result_frame_sync_n_in;
				l_d.wr     = {l_q.wr[CTRL_W-2:0], data_in};
			end
		end else begin
			l_d.edge_n = l_q.edge_n + 5'h01;
			l_d.sh     = {l_q.sh[RES_W-2:0], 1'b0};
			l_d.dout   = l_q.sh[RES_W-2];
			if (l_q.edge_n < CTRL_APPLY_EDGE - 5'h01)
				l_d.wr = {l_q.wr[CTRL_W-2:0], data_in};
			if (l_q.wr_en && l_d.edge_n == CTRL_APPLY_EDGE) begin
				l_d.ctrl = l_q.wr;
				l_d.ctg  = !l_q.ctg;
			end
			if (l_d.edge_n == FRAME_BITS) begin
				// last of sixteen; core may offer the next word
				l_d.act = 1'b0;
				if (l_q.rd)
					l_d.ack = !l_q.ack;
			end
		end
		if (!l_d.act)
			l_d.doe = 1'b0;
	end

	// link registers; this clock may stop between frames
	always_ff @(posedge sclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			l_q      <= '0;
			l_q.ctrl <= CTRL_RESET;
		end else begin
			l_q <= l_d;
		end
	end

	// pin drive: mux of registered sources by the synchronised strap
	assign sclk_out                 = c_q.sclk;
	assign sclk_oe_out              = c_q.mode_s[1];
	assign result_frame_sync_n_out  = c_q.rfs_n;
	assign result_frame_sync_oe_out = c_q.mode_s[1];
	assign data_out    = c_q.mode_s[1] ? c_q.dout : l_q.dout;
	assign data_oe_out = c_q.mode_s[1] ? c_q.doe : l_q.doe;
	assign dac_code_out        = sar_code;
	assign channel_select_out  = c_q.ctrl[CTRL_CH_HI:CTRL_CH_LO];
	assign conversion_busy_out = sar_busy;
endmodule

// ### verification/asr_port_properties.sv
// pin level assertions for the converter serial port
`timescale 1ns/1ps
module asr_port_properties
	import asr_pkg::*;
(
	// watched pins
	input wire logic              clk_in,
	input wire logic              rst_n_in,
	input wire logic              sclk_in,
	input wire logic [CODE_W-1:0] dac_code_out,
	input wire logic              conversion_busy_out,
	input wire logic              sclk_out,
	input wire logic              sclk_oe_out,
	input wire logic              result_frame_sync_n_out,
	input wire logic              result_frame_sync_oe_out,
	input wire logic              write_frame_sync_n_in,
	input wire logic              result_frame_sync_n_in,
	input wire logic              data_out,
	input wire logic              data_oe_out
);
	// a self clocked frame opens
	sequence s_open;
		$fell(result_frame_sync_n_out);
	endsequence
	// one high half of the serial clock, then low
	sequence s_half;
		sclk_out[*4] ##1 !sclk_out;
	endsequence
	AST_SYNC_DRIVERS: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		sclk_oe_out == result_frame_sync_oe_out)
		else $error("clock and sync drivers disagree");
	AST_SCLK_HALF: assert property (
		@(posedge clk_in) disable iff (!rst_n_in) $rose(sclk_out) |-> s_half)
		else $error("serial clock half period wrong");
	AST_FRAME_LEN: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		s_open |-> ##127 !result_frame_sync_n_out ##1 result_frame_sync_n_out)
		else $error("self frame length wrong");
	AST_OPEN_MSB: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		s_open |-> sclk_out && data_oe_out && data_out == 1'b0)
		else $error("frame opened without clock, driver or top bit");
	AST_SELF_OE: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		sclk_oe_out && data_oe_out |-> !result_frame_sync_n_out)
		else $error("data driver on outside a read frame");
	AST_TRIALS: assert property (
		@(negedge clk_in) disable iff (!rst_n_in) $rose(conversion_busy_out)
		|-> dac_code_out == 12'h800 ##1 conversion_busy_out[*8])
		else $error("trial sequence wrong");
	AST_EXT_READ: assert property (
		@(posedge sclk_in) disable iff (!rst_n_in)
		!sclk_oe_out && $rose(data_oe_out) |-> data_oe_out[*8] ##7 data_oe_out)
		else $error("external read frame cut short");
	AST_EXT_WRITE: assert property (
		@(posedge sclk_in) disable iff (!rst_n_in)
		!sclk_oe_out && !write_frame_sync_n_in && result_frame_sync_n_in
		|=> !data_oe_out)
		else $error("data driver on in a write frame");
endmodule
bind asr_port asr_port_properties u_props (.clk_in, .rst_n_in, .sclk_in,
	.dac_code_out, .conversion_busy_out, .sclk_out, .sclk_oe_out,
	.result_frame_sync_n_out, .result_frame_sync_oe_out,
	.write_frame_sync_n_in, .result_frame_sync_n_in, .data_out, .data_oe_out);

// ### verification/asr_host_model.sv
// host serial port model facing the converter port
`timescale 1ns/1ps
module asr_host_model
	import asr_pkg::*;
(
	// mode strap and next control word
	input  wire logic              self_mode_in,
	input  wire logic [CTRL_W-1:0] ctrl_in,
	// device pins as seen on the wires
	input  wire logic              dev_sclk_in,
	input  wire logic              dev_sync_n_in,
	input  wire logic              dev_data_in,
	input  wire logic              dev_oe_in,
	// host drives
	output logic                   sclk_out,
	output logic                   rfs_n_out,
	output logic                   wfs_n_out,
	output logic                   data_out,
	// last self clocked word and frame count
	output logic [RES_W-1:0]       word_out,
	output int                     frames_out
);
	logic             ext_wfs; // separate write sync, host timed
	logic [RES_W-1:0] sh;      // receive shifter
	int               j;       // control bit index
	initial begin
		{sclk_out, rfs_n_out, ext_wfs, data_out} = 4'b0110;
		frames_out = 0;
	end
	// syncs tied in self mode: every result frame also writes
	assign wfs_n_out = self_mode_in ? dev_sync_n_in : ext_wfs;
	// frame start: first control bit goes out at once
	always @(negedge dev_sync_n_in) if (self_mode_in) begin
		j = CTRL_W - 1;
		data_out = ctrl_in[j];
	end
	// take data on falling clock, feed next bit, then idle toggles
	always @(negedge dev_sclk_in) if (self_mode_in && !dev_sync_n_in) begin
		sh = {sh[RES_W-2:0], dev_data_in};
		j--;
		data_out = (j >= 0) ? ctrl_in[j] : ~data_out;
	end
	// word complete after sixteen bits
	always @(posedge dev_sync_n_in) if (self_mode_in) begin
		word_out = sh;
		frames_out++;
		data_out = ~data_out;
	end
	// external frame; link clock runs only inside it, 80 ns period
	task automatic xfer(input logic rd, input logic wr,
		input logic [CTRL_W-1:0] ctl, output logic [RES_W-1:0] w,
		output logic oe);
		w = '0;
		oe = 1'b0;
		rfs_n_out = !rd;
		ext_wfs = !wr;
		data_out = ctl[CTRL_W-1];
		for (int i = 1; i <= RES_W; i++) begin
			#40 sclk_out = 1'b1;
			#40 sclk_out = 1'b0;
			w = {w[RES_W-2:0], dev_data_in};
			oe = oe | dev_oe_in;
			data_out = (wr && i < CTRL_W) ? ctl[CTRL_W-1-i] : ~data_out;
		end
		rfs_n_out = 1'b1;
		ext_wfs = 1'b1;
		#80;
	endtask
endmodule

// ### verification/asr_port_test.sv
// self-checking bench for the converter serial port
`timescale 1ns/1ps
module asr_port_test
	import asr_pkg::*;
;
	logic              clk_in = 1'b0, rst_n_in = 1'b1, mode = 1'b0;
	logic              trig_n = 1'b1, busy, sclk_o, sclk_oe, rfs_o, rfs_oe;
	logic              dout, doe, h_sclk, h_rfs, h_wfs, h_din, comp, s, oe;
	logic [CODE_W-1:0] dac, tgt = 12'hA5C;
	logic [CH_W-1:0]   ch;
	logic [CTRL_W-1:0] ctl = 5'h0D;
	logic [RES_W-1:0]  sword, w;
	int                sframes, failures = 0, n_tests = 0, cyc = 0;
	// pins resolved from whoever drives them
	wire sclk_w = sclk_oe ? sclk_o : h_sclk;
	wire rfs_w = rfs_oe ? rfs_o : h_rfs;
	// comparator: input at tgt is at or above the trial code
	assign comp = (tgt >= dac);
	always #12.5 clk_in = ~clk_in;
	asr_port dut (.clk_in, .rst_n_in, .self_clock_mode_in(mode),
		.conversion_trigger_n_in(trig_n), .comp_in(comp), .dac_code_out(dac),
		.channel_select_out(ch), .conversion_busy_out(busy),
		.sclk_in(sclk_w), .sclk_out(sclk_o), .sclk_oe_out(sclk_oe),
		.result_frame_sync_n_in(rfs_w), .result_frame_sync_n_out(rfs_o),
		.result_frame_sync_oe_out(rfs_oe), .write_frame_sync_n_in(h_wfs),
		.data_in(h_din), .data_out(dout), .data_oe_out(doe));
	asr_host_model host (.self_mode_in(mode), .ctrl_in(ctl),
		.dev_sclk_in(sclk_w), .dev_sync_n_in(rfs_w), .dev_data_in(dout),
		.dev_oe_in(doe), .sclk_out(h_sclk), .rfs_n_out(h_rfs),
		.wfs_n_out(h_wfs), .data_out(h_din), .word_out(sword),
		.frames_out(sframes));
	// compare and count
	task automatic chk(input logic [RES_W-1:0] got, input logic [RES_W-1:0] e);
		n_tests++;
		if (got !== e) begin
			failures++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, e);
		end
	endtask
	// hold reset, check the idle pins, then release off the clock edge
	task automatic reset_dut(input int n);
		rst_n_in = 1'b0;
		repeat (n) @(negedge clk_in);
		chk(16'({rfs_o, sclk_oe, rfs_oe, doe}), 16'h8);
		rst_n_in = 1'b1;
	endtask
	// pin start, chosen over the command for wideband use
	task automatic fire();
		@(negedge clk_in) trig_n = 1'b0;
		repeat (3) @(negedge clk_in);
		trig_n = 1'b1;
	endtask
	// wait for a conversion to run and end; a read can run alongside
	task automatic conv(input logic pin, output logic seen);
		seen = 1'b0;
		if (pin) fire();
		for (int k = 0; k < 120; k++) begin
			@(negedge clk_in);
			if (busy === 1'b1) seen = 1'b1;
			else if (seen) break;
		end
	endtask
	// bounded wait for self clocked frames
	task automatic frames(input int n);
		for (int k = 0; k < 400 && sframes < n; k++) @(negedge clk_in);
		chk(16'(sframes), 16'(n));
	endtask
	// self clocking: results arrive unasked, writes ride along
	task automatic t_self();
		mode = 1'b1;
		repeat (4) @(negedge clk_in);
		conv(1'b1, s);
		conv(1'b0, s);
		chk(16'(s), 16'h1);
		ctl = 5'h00; // next word set up before it is sent
		frames(1);
		chk(sword, {4'h0, tgt});
		chk(16'(ch), 16'h3);
		frames(2);
		chk(sword, {4'h3, tgt});
		chk(16'(ch), 16'h0);
	endtask
	// external clocking: reads, writes, start during a read
	task automatic t_ext();
		mode = 1'b0;
		tgt = 12'h5A3;
		// a strap change is only taken cleanly across a reset
		reset_dut(3);
		repeat (4) @(negedge clk_in);
		conv(1'b1, s); // past the twelve trials of the first conversion
		fork
			host.xfer(1'b1, 1'b1, 5'h1D, w, oe);
			conv(1'b0, s);
		join
		chk(w, {4'h0, tgt});
		chk(16'({s, oe}), 16'h3);
		repeat (8) @(negedge clk_in);
		chk(16'(ch), 16'h7);
		host.xfer(1'b0, 1'b1, 5'h00, w, oe);
		chk(16'(oe), 16'h0);
		repeat (8) @(negedge clk_in);
		host.xfer(1'b1, 1'b0, 5'h00, w, oe);
		chk(w, {4'h7, tgt});
	endtask
	// three words held while the host stalls, a fourth start refused:
	// one waits in the offered word, two in the buffer
	task automatic t_buffer();
		tgt = 12'h123;
		conv(1'b1, s);
		tgt = 12'h456;
		conv(1'b1, s);
		tgt = 12'h789;
		conv(1'b1, s);
		conv(1'b1, s);
		chk(16'(s), 16'h0);
		repeat (8) @(negedge clk_in);
		host.xfer(1'b1, 1'b0, 5'h00, w, oe);
		chk(w, 16'h0123);
		repeat (8) @(negedge clk_in);
		host.xfer(1'b1, 1'b0, 5'h00, w, oe);
		chk(w, 16'h0456);
		repeat (8) @(negedge clk_in);
		host.xfer(1'b1, 1'b0, 5'h00, w, oe);
		chk(w, 16'h0789);
	endtask
	task automatic conclude();
		$display("checks %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// a hang stops well past the expected run of about a thousand cycles
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 8000) begin
			failures++;
			conclude();
		end
	end
	initial begin
		// a real falling reset edge, so both clock domains start clean
		#2;
		reset_dut(10);
		t_self();
		t_ext();
		t_buffer();
		conclude();
	end
endmodule
